// File: design/lcr_pkg.sv
// constants for the led output control register bank
package lcr_pkg;
    localparam int NUM_OUT = 9;
    localparam int DUTY_W = 12;
    localparam logic [7:0] ADDR_RATIO_HIGH = 8'h02;
    localparam logic [7:0] ADDR_RATIO_LOW = 8'h03;
    localparam logic [7:0] ADDR_SWITCH_HIGH = 8'h04;
    localparam logic [7:0] ADDR_SWITCH_LOW = 8'h05;
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'h06;
    localparam logic [7:0] ADDR_CTRL_LAST = 8'h0E;
    localparam logic [7:0] ADDR_PWM_FIRST = 8'h16;
    localparam logic [7:0] ADDR_PWM_LAST = 8'h1E;
    localparam logic [7:0] ADDR_FADER_FIRST = 8'h40;
    localparam logic [7:0] ADDR_FADER_LAST = 8'h42;
    localparam logic [7:0] ADDR_STATE_HIGH = 8'h43;
    localparam logic [7:0] ADDR_STATE_LOW = 8'h44;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [8:0] RESET_BITS9 = 9'h000;
    localparam int MAP_HI = 7;
    localparam int MAP_LO = 6;
    localparam int LOG_BIT = 5;
    localparam int SLOPE_HI = 4;
    localparam logic [1:0] MAP_NONE = 2'h0;
    localparam logic [4:0] SLOPE_OFF = 5'h00;
    localparam int REF_TEMP_C = 25;
    localparam int SLOPE_STEPS_PER_UNIT = 10;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 12'hFFF;
endpackage : lcr_pkg

// File: design/lcr_led_output_control_regs.sv
// register bank and duty path for the nine led outputs
//
// Functional notes
// - ratiometric outputs scale proportionally with their fader
// - ratio enable bits at 0x02 and 0x03
// - on/off bits at 0x04 and 0x05
// - engine selection overrides register on/off
// - per-output fader mapping none or 1..3
// - mapped output with ratio enable set: duty is pwm times fader
// - per-output linear or logarithmic scaling select
// - logarithmic path works at 12-bit resolution
// - temperature compensation per output, own slope
// - final duty = (set - (25-T)*slope*set)/2
// - set duty from pwm registers 0x16..0x1E, or from ENG_PWM while ENG_SEL selects the output
// - slope 00000 disables compensation, scaled and faded duty passes through
// - fader mapping field bits 7:6, reset 00
// - log bit 5 applies to engine and direct
// - slope bits 4:0 signed tenths, reference 25
`timescale 1ns/1ps
module lcr_led_output_control_regs #(
    parameter int NUM_OUT = 9,
    parameter int DUTY_W = 12
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] TEMP_C,
    input wire logic [NUM_OUT-1:0] ENG_SEL,
    input wire logic [NUM_OUT-1:0] ENG_ON,
    input wire logic [NUM_OUT*8-1:0] ENG_PWM,
    output logic [7:0] RDATA,
    output logic [NUM_OUT-1:0] OUT_ON,
    output logic [NUM_OUT*DUTY_W-1:0] OUT_DUTY
);
    import lcr_pkg::*;

    logic [NUM_OUT-1:0] out_proportional_dim_on;
    logic [NUM_OUT-1:0] out_source_active;
    logic [7:0] out_ctrl [NUM_OUT];
    logic [7:0] out_duty_value [NUM_OUT];
    logic [7:0] fader [3];
    wire logic [NUM_OUT-1:0] next_on;
    wire logic [NUM_OUT*DUTY_W-1:0] next_duty;
    logic [7:0] next_rdata;

    // write decode; each register compares its address once
    logic wr_ratio_high;
    logic wr_ratio_low;
    logic wr_switch_high;
    logic wr_switch_low;
    logic [NUM_OUT-1:0] wr_ctrl;
    logic [NUM_OUT-1:0] wr_pwm;
    logic [2:0] wr_fader;
    assign wr_ratio_high = WR && ADDR == ADDR_RATIO_HIGH;
    assign wr_ratio_low = WR && ADDR == ADDR_RATIO_LOW;
    assign wr_switch_high = WR && ADDR == ADDR_SWITCH_HIGH;
    assign wr_switch_low = WR && ADDR == ADDR_SWITCH_LOW;
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_dec
        assign wr_ctrl[i] = WR && ADDR == ADDR_CTRL_FIRST + 8'(i);
        assign wr_pwm[i] = WR && ADDR == ADDR_PWM_FIRST + 8'(i);
    end
    // fader levels feed the mapping and the read mux; their own control lives elsewhere
    for (genvar f = 0; f < 3; f++) begin : g_fdec
        assign wr_fader[f] = WR && ADDR == ADDR_FADER_FIRST + 8'(f);
    end

    // ratio enable bits; only bit 0 exists in the high byte
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            out_proportional_dim_on <= RESET_BITS9;
        end else if (wr_ratio_high) begin
            out_proportional_dim_on[8] <= WDATA[0];
        end else if (wr_ratio_low) begin
            out_proportional_dim_on[7:0] <= WDATA;
        end
    end

    // on/off bits; high byte bits 7:1 have no storage, writes there vanish
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            out_source_active <= RESET_BITS9;
        end else if (wr_switch_high) begin
            out_source_active[8] <= WDATA[0];
        end else if (wr_switch_low) begin
            out_source_active[7:0] <= WDATA;
        end
    end

    // per-output control bytes
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                out_ctrl[i] <= RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (wr_ctrl[i]) begin
                    out_ctrl[i] <= WDATA;
                end
            end
        end
    end

    // per-output pwm bytes
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                out_duty_value[i] <= RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (wr_pwm[i]) begin
                    out_duty_value[i] <= WDATA;
                end
            end
        end
    end

    // group fader levels
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int f = 0; f < 3; f++) begin
                fader[f] <= RESET_BYTE;
            end
        end else begin
            for (int f = 0; f < 3; f++) begin
                if (wr_fader[f]) begin
                    fader[f] <= WDATA;
                end
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        next_rdata = RESET_BYTE;
        case (ADDR)
            ADDR_RATIO_HIGH: begin
                next_rdata = {7'h00, out_proportional_dim_on[8]};
            end
            ADDR_RATIO_LOW: begin
                next_rdata = out_proportional_dim_on[7:0];
            end
            ADDR_SWITCH_HIGH: begin
                next_rdata = {7'h00, out_source_active[8]};
            end
            ADDR_SWITCH_LOW: begin
                next_rdata = out_source_active[7:0];
            end
            ADDR_STATE_HIGH: begin
                next_rdata = {7'h00, OUT_ON[8]};
            end
            ADDR_STATE_LOW: begin
                next_rdata = OUT_ON[7:0];
            end
            default: begin
                next_rdata = RESET_BYTE;
            end
        endcase
        for (int i = 0; i < NUM_OUT; i++) begin
            if (ADDR == ADDR_CTRL_FIRST + 8'(i)) begin
                next_rdata = out_ctrl[i];
            end
            if (ADDR == ADDR_PWM_FIRST + 8'(i)) begin
                next_rdata = out_duty_value[i];
            end
        end
        for (int f = 0; f < 3; f++) begin
            if (ADDR == ADDR_FADER_FIRST + 8'(f)) begin
                next_rdata = fader[f];
            end
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= RESET_BYTE;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= RESET_BYTE;
        end
    end

    // duty path, one copy per output
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
        lcr_duty_path #(
            .DUTY_W(DUTY_W)
        ) u_path (
            .eng_sel(ENG_SEL[g]),
            .eng_on(ENG_ON[g]),
            .eng_level(ENG_PWM[g*8 +: 8]),
            .reg_level(out_duty_value[g]),
            .ctrl(out_ctrl[g]),
            .ratio_on(out_proportional_dim_on[g]),
            .switch_on(out_source_active[g]),
            .fader_one(fader[0]),
            .fader_two(fader[1]),
            .fader_three(fader[2]),
            .temp_c(TEMP_C),
            .duty(next_duty[g*DUTY_W +: DUTY_W]),
            .src_on(next_on[g])
        );
    end

    // effective on/off, engine or register
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            OUT_ON <= '0;
        end else begin
            OUT_ON <= next_on;
        end
    end

    // final duty per output
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            OUT_DUTY <= '0;
        end else begin
            OUT_DUTY <= next_duty;
        end
    end
endmodule : lcr_led_output_control_regs

// per-output duty and on/off path
module lcr_duty_path #(
    parameter int DUTY_W = 12
) (
    input wire logic eng_sel,
    input wire logic eng_on,
    input wire logic [7:0] eng_level,
    input wire logic [7:0] reg_level,
    input wire logic [7:0] ctrl,
    input wire logic ratio_on,
    input wire logic switch_on,
    input wire logic [7:0] fader_one,
    input wire logic [7:0] fader_two,
    input wire logic [7:0] fader_three,
    input wire logic [7:0] temp_c,
    output logic [DUTY_W-1:0] duty,
    output logic src_on
);
    import lcr_pkg::*;

    // stage values, all combinational
    logic [7:0] base;
    logic [1:0] map_sel;
    logic [4:0] slope;
    logic [DUTY_W-1:0] scaled;
    logic [DUTY_W-1:0] faded;
    logic [DUTY_W-1:0] comp;
    logic [19:0] product;
    logic [7:0] fader_level;
    logic signed [15:0] temp_delta;
    logic signed [31:0] factor;
    logic signed [31:0] term;
    logic signed [31:0] final_val;

    assign map_sel = ctrl[MAP_HI:MAP_LO];
    assign slope = ctrl[SLOPE_HI:0];
    // engine drives the level while it holds the output
    assign base = eng_sel ? eng_level : reg_level;
    assign src_on = eng_sel ? eng_on : switch_on;

    // log curve: 3-bit exponent, 5-bit mantissa into 12 bits
    // an approximation; the mantissa carries an implied leading one
    always_comb begin
        if (ctrl[LOG_BIT]) begin
            if (base == 8'h00) begin
                scaled = 12'h000;
            end else begin
                scaled = DUTY_W'((({7'h00, 1'b1, base[4:0]} << base[7:5]) >> 1));
            end
        end else begin
            scaled = {base, base[7:4]};
        end
    end

    // fader pick; mapping 00 has no fader, so the level goes unused
    always_comb begin
        case (map_sel)
            2'h1: begin
                fader_level = fader_one;
            end
            2'h2: begin
                fader_level = fader_two;
            end
            2'h3: begin
                fader_level = fader_three;
            end
            default: begin
                fader_level = RESET_BYTE;
            end
        endcase
    end

    // proportional scaling keeps colour mix across channels
    always_comb begin
        product = 20'(scaled) * 20'(fader_level);
        if (map_sel != MAP_NONE && ratio_on) begin
            faded = product[19:8];
        end else begin
            faded = scaled;
        end
    end

    // signed throughout so that negative slopes do not wrap around
    always_comb begin
        temp_delta = 16'(REF_TEMP_C) - 16'(signed'(temp_c));
        factor = 32'(temp_delta) * 32'(signed'(slope));
        term = (signed'(32'(faded)) * factor) / SLOPE_STEPS_PER_UNIT;
        final_val = (signed'(32'(faded)) - term) / 2;
    end

    // hazard: large slopes overshoot, so clamp to the duty range
    always_comb begin
        if (final_val < 0) begin
            comp = 12'h000;
        end else if (final_val > 32'(DUTY_MAX)) begin
            comp = DUTY_MAX;
        end else begin
            comp = final_val[DUTY_W-1:0];
        end
    end

    // slope zero bypasses compensation entirely
    always_comb begin
        if (slope == SLOPE_OFF) begin
            duty = faded;
        end else begin
            duty = comp;
        end
    end
endmodule : lcr_duty_path

// File: test/lcr_regs_properties.sv
// assertions on the register port and on/off outputs
`timescale 1ns/1ps
module lcr_regs_properties #(
    parameter int NUM_OUT = 9
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [NUM_OUT-1:0] ENG_SEL,
    input wire logic [NUM_OUT-1:0] ENG_ON,
    input wire logic [7:0] RDATA,
    input wire logic [NUM_OUT-1:0] OUT_ON
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    a_rdata_idle_zero:
        assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data outside answer");
    a_switch_low_out:
        assert property ((WR && ADDR == 8'h05) ##1 (ENG_SEL == '0) |=> OUT_ON[7:0] == $past(WDATA, 2))
        else $error("low switch bits not on outputs");
    a_switch_high_out:
        assert property ((WR && ADDR == 8'h04) ##1 (ENG_SEL == '0) |=> OUT_ON[8] == $past(WDATA[0], 2))
        else $error("output nine switch wrong");
    a_ratio_readback:
        assert property ((WR && ADDR == 8'h03) ##1 (RD && ADDR == 8'h03) |=> RDATA == $past(WDATA, 2))
        else $error("ratio readback wrong");
    a_switch_readback:
        assert property ((WR && ADDR == 8'h05) ##1 (RD && ADDR == 8'h05) |=> RDATA == $past(WDATA, 2))
        else $error("switch readback wrong");
    a_unused_bits_zero:
        assert property (RD && (ADDR == 8'h02 || ADDR == 8'h04) |=> RDATA[7:1] == 7'h00)
        else $error("unused bits not zero");
    a_unmapped_read_zero:
        assert property (RD && ADDR >= 8'h1F && ADDR <= 8'h3F |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_engine_overrides:
        assert property ($past(RSTN) && ENG_SEL != '0 |=> ((OUT_ON ^ $past(ENG_ON)) & $past(ENG_SEL)) == '0)
        else $error("engine selection ignored");
endmodule : lcr_regs_properties
bind lcr_led_output_control_regs lcr_regs_properties #(.NUM_OUT(NUM_OUT)) u_props (.CLK_SYS(CLK_SYS),
    .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .ENG_SEL(ENG_SEL), .ENG_ON(ENG_ON),
    .RDATA(RDATA), .OUT_ON(OUT_ON));

// File: test/lcr_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module lcr_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] wdata = 8'h00,
    output logic wr = 1'b0,
    output logic rd = 1'b0
);
    // the write strobe stays up until the next call so writes can run back to back
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
    endtask : write
    // answer stands one cycle only, so sample just after the taking edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : read
    task automatic pause(input int n);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : pause
endmodule : lcr_host_model

// File: test/lcr_led_output_control_regs_bench.sv
// self-checking bench for the led output control registers
`timescale 1ns/1ps
module lcr_led_output_control_regs_bench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wr, rd;
    logic [7:0] addr, wdata, rdata, d;
    logic [7:0] temp_c = 8'h19;
    logic [8:0] eng_sel = 9'h000, eng_on = 9'h000, out_on;
    logic [71:0] eng_pwm = 72'h0;
    logic [107:0] out_duty;
    int errors = 0, n_tests = 0, cycles = 0;
    always #4 clk_sys = ~clk_sys;
    lcr_host_model host (.clk(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    lcr_led_output_control_regs uut (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .TEMP_C(temp_c), .ENG_SEL(eng_sel), .ENG_ON(eng_on), .ENG_PWM(eng_pwm), .RDATA(rdata),
        .OUT_ON(out_on), .OUT_DUTY(out_duty));
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic conclude();
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // whole run is under a hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end
    // output one: control byte and temperature, then duty
    task automatic duty(input logic [7:0] c, input logic [7:0] t, input logic [11:0] e);
        host.write(8'h06, c);
        temp_c <= t;
        host.pause(3);
        chk(out_duty[11:0], e);
    endtask : duty
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 2; i < 6; i++) begin
            host.read(8'(i), d);
            chk(d, 12'h000);
        end
        host.write(8'h02, 8'hFF);
        host.read(8'h02, d);
        chk(d, 12'h001);
        host.write(8'h03, 8'h01);
        host.read(8'h03, d);
        chk(d, 12'h001);
        host.write(8'h04, 8'hFF);
        host.write(8'h05, 8'h81);
        host.read(8'h05, d);
        chk(d, 12'h081);
        host.read(8'h30, d);
        chk(d, 12'h000);
        host.pause(2);
        chk(out_on, 12'h181);
        host.read(8'h44, d);
        chk(d, 12'h081);
        host.read(8'h43, d);
        chk(d, 12'h001);
        eng_sel <= 9'h003;
        eng_on <= 9'h002;
        eng_pwm <= 72'h80;
        host.pause(3);
        chk(out_on, 12'h182);
        chk(out_duty[11:0], 12'h808);
        eng_sel <= 9'h000;
        host.write(8'h16, 8'h80);
        host.write(8'h40, 8'h80);
        host.write(8'h41, 8'h40);
        host.write(8'h42, 8'hFF);
        duty(8'h00, 8'h19, 12'h808);
        duty(8'h20, 8'h19, 12'h100);
        duty(8'h40, 8'h19, 12'h404);
        duty(8'h80, 8'h19, 12'h202);
        duty(8'hC0, 8'h19, 12'h7FF);
        duty(8'h0F, 8'h19, 12'h404);
        duty(8'h01, 8'h18, 12'h39D);
        duty(8'h1F, 8'h18, 12'h46A);
        conclude();
    end
endmodule : lcr_led_output_control_regs_bench
